// ===== rtl/line_out_consts.svh
// Constants for the line-output gain and headphone startup register bank.
// Assumes a 10 MHz core clock and a page register outside the bank.
`ifndef LINE_OUT_CONSTS_SVH
`define LINE_OUT_CONSTS_SVH

// Page and register offsets
`define PAGE_ONE          8'h01
`define LEFT_GAIN_OFS     8'h12
`define RIGHT_GAIN_OFS    8'h13
`define HP_START_OFS      8'h14
`define STATUS_OFS        8'h7f

// Field positions
`define MUTE_BIT          6
`define GAIN_MSB          5
`define STEP_MSB          7
`define STEP_LSB          6
`define RAMP_MSB          5
`define RAMP_LSB          2
`define RES_MSB           1

// Reset values
`define LINE_RST          7'h40
`define HP_RST            8'h00

// Reserved gain codes
`define GAIN_RSV_LO       6'h20
`define GAIN_RSV_HI       6'h39
`define GAIN_TOP_RSV      6'h1e

// Ramp and resistance codes
`define RAMP_LONG_MIN     4'hd
`define RES_25K           2'h0
`define RES_RSV           2'h3

// Status bits
`define ST_BUSY           0
`define ST_DONE           1
`define ST_LGAIN          2
`define ST_RGAIN          3
`define ST_RAMP           4
`define ST_RES            5

// Time base: 1 ms in ns, divided by the clock period, rounded up
`define CLK_PERIOD_NS     100
`define TIME_BASE_NS      1000000
`define TICK_CYCLES       ((`TIME_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Soft routing step times in ms
`define STEP_MS_1         8'd50
`define STEP_MS_2         8'd100
`define STEP_MS_3         8'd200

// Ramp lengths in thousandths of a time constant
`define RAMP_TC_1         16'd500
`define RAMP_TC_2         16'd625
`define RAMP_TC_3         16'd725
`define RAMP_TC_4         16'd875
`define RAMP_TC_5         16'd1000
`define RAMP_TC_6         16'd2000
`define RAMP_TC_7         16'd3000
`define RAMP_TC_8         16'd4000
`define RAMP_TC_9         16'd5000
`define RAMP_TC_A         16'd6000
`define RAMP_TC_B         16'd7000
`define RAMP_TC_C         16'd8000
`define RAMP_TC_16        16'd16000
`define RAMP_TC_32        16'd32000

`endif

// ===== rtl/line_out_gain_hp_startup_regs.sv
// Line-output gain and headphone startup register bank of an audio codec.
// Assumes a 10 MHz clock, a page register outside, and a same-clock bus.
//
// Behaviour
// (R01) Left mute bit 6 mutes the left line output when set and resets to 1.
// (R02) Right mute bit 6 mutes the right line output when set and resets to 1.
// (R03) Left bits 5..0 hold a signed 1 dB gain code, -6 to +29 dB, reset 0 dB.
// (R04) Software keeps off gain codes 0x20..0x39 and 0x1e..0x1f.
// (R05) Right bits 5..0 use the same gain code as the left, reset zero.
// (R06) Bit 7 of both line-output registers reads 0 and is written as 0.
// (R07) Headphone bits 7..6 pick the routing step time 0, 50, 100 or 200 ms.
// (R08) Headphone ramp field 0000, its reset value, turns the slow ramp off.
// (R09) Nonzero ramp codes pick 0.5 up to 32 time constants of slow ramp.
// (R10) Software avoids ramp codes 1101..1111 with the 25k charge resistor.
// (R11) Headphone bits 1..0 pick 25k, 6k or 2k charge resistance; 11 is unused.
// (R12) The three registers sit on page 1 at 0x12, 0x13 and 0x14.
// (R13) The routing step time is measured from a fixed 1 ms time base.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "line_out_consts.svh"

module line_out_gain_hp_startup_regs #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic [7:0]               page,
  input  wire logic [7:0]               addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [7:0]               rd_data,
  input  wire logic                     route_step_req,
  output logic                          left_line_output_mute,
  output line_out_pkg::gain_t           left_line_output_gain,
  output logic                          right_line_output_mute,
  output line_out_pkg::gain_t           right_line_output_gain,
  output line_out_pkg::step_sel_t       route_step_sel,
  output line_out_pkg::ramp_code_t      ramp_code,
  output line_out_pkg::res_sel_t        charge_res_sel,
  output logic                          ramp_enable,
  output logic      [15:0]              ramp_tc_milli,
  output logic                          route_step_busy,
  output logic                          route_step_done,
  output logic                          cfg_fault
);
  import line_out_pkg::*;

  // Reset release through two flops; kept off the clock enable so that a
  // frozen block can still be reset
  logic rst_meta_q;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // Reserved line-output gain codes
  function automatic logic gain_reserved(input gain_t code);
    gain_reserved = ((code >= `GAIN_RSV_LO) && (code <= `GAIN_RSV_HI)) ||
                    (code >= `GAIN_TOP_RSV && code < `GAIN_RSV_LO);
  endfunction : gain_reserved

  // Slow ramp length in thousandths of a time constant
  function automatic logic [15:0] ramp_tc(input ramp_code_t code);
    unique case (code)
      4'h0: ramp_tc = 16'h0000;
      4'h1: ramp_tc = `RAMP_TC_1;
      4'h2: ramp_tc = `RAMP_TC_2;
      4'h3: ramp_tc = `RAMP_TC_3;
      4'h4: ramp_tc = `RAMP_TC_4;
      4'h5: ramp_tc = `RAMP_TC_5;
      4'h6: ramp_tc = `RAMP_TC_6;
      4'h7: ramp_tc = `RAMP_TC_7;
      4'h8: ramp_tc = `RAMP_TC_8;
      4'h9: ramp_tc = `RAMP_TC_9;
      4'ha: ramp_tc = `RAMP_TC_A;
      4'hb: ramp_tc = `RAMP_TC_B;
      4'hc: ramp_tc = `RAMP_TC_C;
      4'hd: ramp_tc = `RAMP_TC_16;
      4'he: ramp_tc = `RAMP_TC_32;
      4'hf: ramp_tc = `RAMP_TC_32;
    endcase
  endfunction : ramp_tc

  // Address decode on page 1 only
  wire on_page  = (page == `PAGE_ONE);
  wire hit_left = on_page && (addr == `LEFT_GAIN_OFS); // (R12)
  wire hit_right = on_page && (addr == `RIGHT_GAIN_OFS); // (R12)
  wire hit_hp   = on_page && (addr == `HP_START_OFS); // (R12)
  wire hit_stat = on_page && (addr == `STATUS_OFS);

  wire wr_left  = ce && wr_en && hit_left;
  wire wr_right = ce && wr_en && hit_right;
  wire wr_hp    = ce && wr_en && hit_hp;
  wire rd_stat  = ce && rd_en && hit_stat;

  // Stored bits; bit 7 of the line registers has no flop at all
  logic [6:0] left_q;
  logic [6:0] right_q;
  logic [7:0] hp_q;

  // Line-output registers: mute and gain
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      left_q  <= `LINE_RST; // (R01) (R03)
      right_q <= `LINE_RST; // (R02) (R05)
    end
    else
    begin
      if (wr_left)
        left_q <= wr_data[`MUTE_BIT:0]; // (R01) (R03) (R06)
      if (wr_right)
        right_q <= wr_data[`MUTE_BIT:0]; // (R02) (R05) (R06)
    end
  end

  // Headphone startup register; every bit is writable
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      hp_q <= `HP_RST; // (R07) (R08) (R11)
    else if (wr_hp)
      hp_q <= wr_data; // (R07) (R08) (R11)
  end

  // Field outputs straight from the register flops
  assign left_line_output_mute  = left_q[`MUTE_BIT]; // (R01)
  assign left_line_output_gain  = left_q[`GAIN_MSB:0]; // (R03)
  assign right_line_output_mute = right_q[`MUTE_BIT]; // (R02)
  assign right_line_output_gain = right_q[`GAIN_MSB:0]; // (R05)
  assign route_step_sel         = hp_q[`STEP_MSB:`STEP_LSB]; // (R07)
  assign ramp_code              = hp_q[`RAMP_MSB:`RAMP_LSB]; // (R08)
  assign charge_res_sel         = hp_q[`RES_MSB:0]; // (R11)

  // Ramp decode, registered so the analog side sees clean levels;
  // this costs one cycle of lag behind a register write
  logic        ramp_en_q;
  logic [15:0] ramp_tc_q;
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ramp_en_q <= 1'b0;
      ramp_tc_q <= 16'h0000;
    end
    else if (ce)
    begin
      ramp_en_q <= (ramp_code != 4'h0); // (R08)
      ramp_tc_q <= ramp_tc(ramp_code); // (R09)
    end
  end
  assign ramp_enable   = ramp_en_q;
  assign ramp_tc_milli = ramp_tc_q;

  // Soft routing step timer
  logic step_busy;
  logic step_done;
  step_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_step_timer (
    .clock    (clock),
    .rst_n    (rst_sync_n),
    .ce       (ce),
    .start    (route_step_req),
    .step_sel (route_step_sel),
    .busy     (step_busy),
    .done     (step_done)
  );
  assign route_step_busy = step_busy;
  assign route_step_done = step_done;

  // Misuse checks: the device keeps what software writes, but reports it
  wire l_rsv   = gain_reserved(left_q[`GAIN_MSB:0]); // (R04)
  wire r_rsv   = gain_reserved(right_q[`GAIN_MSB:0]); // (R04)
  wire rmp_bad = (charge_res_sel == `RES_25K) && (ramp_code >= `RAMP_LONG_MIN); // (R10)
  wire res_bad = (charge_res_sel == `RES_RSV); // (R11)

  // Fault levels and the sticky step-done flag; a new done beats the
  // clear by a status read in the same cycle
  logic [3:0] fault_q;
  logic       done_seen_q;
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fault_q     <= 4'h0;
      done_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      fault_q     <= {res_bad, rmp_bad, r_rsv, l_rsv};
      done_seen_q <= step_done || (done_seen_q && !rd_stat);
    end
  end
  assign cfg_fault = |fault_q;

  // Status word
  wire [7:0] status_w = {2'h0, fault_q[3], fault_q[2], fault_q[1], fault_q[0],
                         done_seen_q, step_busy};

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux = hit_left  ? {1'b0, left_q} : // (R06)
                      hit_right ? {1'b0, right_q} : // (R06)
                      hit_hp    ? hp_q :
                      hit_stat  ? status_w :
                                  8'h00;

  // Read data stand for the one cycle after the strobe
  logic [7:0] rd_data_q;
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_data_q <= 8'h00;
    else if (ce)
      rd_data_q <= rd_en ? rd_mux : 8'h00;
  end
  assign rd_data = rd_data_q;

  // Named steps of a bus access
  sequence left_wr_s;
    ce && wr_en && hit_left;
  endsequence

  sequence right_wr_s;
    ce && wr_en && hit_right;
  endsequence

  sequence hp_wr_s;
    ce && wr_en && hit_hp;
  endsequence

  sequence line_rd_s;
    ce && rd_en && (hit_left || hit_right);
  endsequence

  left_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R01)
    left_wr_s |=> (left_line_output_mute == $past(wr_data[6])) &&
                  (left_line_output_gain == $past(wr_data[5:0])))
    else $error("left line register did not take the write");

  right_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R05)
    right_wr_s |=> (right_line_output_mute == $past(wr_data[6])) &&
                   (right_line_output_gain == $past(wr_data[5:0])))
    else $error("right line register did not take the write");

  mute_reset_a: assert property (@(posedge clock) // (R02)
    $rose(rst_sync_n) |-> left_line_output_mute && right_line_output_mute &&
                          left_line_output_gain == 6'h00 &&
                          right_line_output_gain == 6'h00)
    else $error("line outputs not muted at 0 dB after reset");

  rsvd_bit_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R06)
    line_rd_s |=> (rd_data[7] == 1'b0))
    else $error("reserved bit 7 read back as one");

  left_readback_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R12)
    (ce && rd_en && hit_left) |=> (rd_data == {1'b0, $past(left_q)}))
    else $error("left line register not found at its offset");

  hp_fields_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R11)
    hp_wr_s |=> (route_step_sel == $past(wr_data[7:6])) &&
                (ramp_code == $past(wr_data[5:2])) &&
                (charge_res_sel == $past(wr_data[1:0])))
    else $error("headphone startup fields did not take the write");

  ramp_off_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R08)
    (hp_wr_s and (wr_data[5:2] == 4'h0)) ##1 ce |=> !ramp_enable && ramp_tc_milli == 16'h0000)
    else $error("slow ramp still enabled with code zero");

  ramp_half_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R09)
    (hp_wr_s and (wr_data[5:2] == 4'h1)) ##1 ce |=> ramp_enable && ramp_tc_milli == 16'd500)
    else $error("ramp code one is not half a time constant");

  gain_fault_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R04)
    (left_wr_s and (wr_data[5:0] == 6'h20)) ##1 ce |=> cfg_fault)
    else $error("reserved gain code not reported");

  step_start_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R13)
    (ce && route_step_req && !route_step_busy && !route_step_done &&
     route_step_sel != 2'h0) |=> route_step_busy [*2])
    else $error("routing step did not start and hold");

  rd_idle_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (ce && !rd_en) |=> (rd_data == 8'h00))
    else $error("read data present without a read");

  // Register map checks
  right_readback_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R12)
    (ce && rd_en && hit_right) |=> (rd_data == {1'b0, $past(right_q)}))
    else $error("right line register not found at its offset");

  hp_readback_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R12)
    (ce && rd_en && hit_hp) |=> (rd_data == $past(hp_q)))
    else $error("headphone startup register not found at its offset");

  unmapped_rd_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R12)
    (ce && rd_en && !(hit_left || hit_right || hit_hp || hit_stat)) |=> (rd_data == 8'h00))
    else $error("unmapped read returned data");

  other_page_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R12)
    (ce && wr_en && !on_page) |=> $stable(left_q) && $stable(right_q) && $stable(hp_q))
    else $error("write on another page changed a register");

  // A frozen block must hold every register and output level
  ce_freeze_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !ce |=> $stable(left_q) && $stable(right_q) && $stable(hp_q) && $stable(rd_data) &&
            $stable(ramp_tc_milli) && $stable(cfg_fault) && $stable(route_step_busy))
    else $error("state moved while the clock enable was low");

  hp_reset_a: assert property (@(posedge clock) // (R07)
    $rose(rst_sync_n) |-> route_step_sel == 2'h0 && ramp_code == 4'h0 &&
                          charge_res_sel == 2'h0 && !ramp_enable && !cfg_fault)
    else $error("headphone startup fields not cleared after reset");

  // Fault flag judged from the gain code the driver sees, not the decode
  gain_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R04)
    (ce && (left_line_output_gain inside {[6'h20:6'h39], 6'h1e, 6'h1f})) |=> cfg_fault)
    else $error("reserved left gain code not flagged");

  // Step timer as seen at the ports and in the status word
  req_ignored_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R13)
    (ce && route_step_req && route_step_busy) |=> (route_step_busy || route_step_done))
    else $error("routing step request broke a running step");

  done_pulse_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R13)
    (ce && route_step_done) |=> !route_step_done)
    else $error("step done lasted more than one cycle");

  done_status_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R13)
    (ce && rd_en && hit_stat && done_seen_q) |=> rd_data[1])
    else $error("step done not shown in the status word");

  done_clear_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // (R13)
    (ce && rd_en && hit_stat && !step_done) |=> !done_seen_q)
    else $error("status read did not clear step done");

endmodule : line_out_gain_hp_startup_regs

// ===== rtl/line_out_pkg.sv
// Types shared by the register bank and its step timer.
// Assumes the constants header sits beside it.
package line_out_pkg;

  typedef logic [5:0] gain_t;
  typedef logic [1:0] step_sel_t;
  typedef logic [3:0] ramp_code_t;
  typedef logic [1:0] res_sel_t;

  // Soft routing step timer states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } step_state_e;

endpackage : line_out_pkg

// ===== rtl/step_timer.sv
// Soft routing step timer: one step of the programmed length per start.
// Assumes start comes from logic on the same clock and a synchronised reset.
`timescale 1ns/10ps
`include "line_out_consts.svh"

module step_timer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic                   start,
  input  wire line_out_pkg::step_sel_t step_sel,
  output logic                        busy,
  output logic                        done
);
  import line_out_pkg::*;

  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

  step_state_e    state_q;
  step_state_e    state_d;
  logic [PW-1:0]  pre_q;
  logic [7:0]     ms_q;
  logic [7:0]     target_q;

  // Step length in ms for a select code
  function automatic logic [7:0] step_ms(input step_sel_t sel);
    unique case (sel)
      2'h0: step_ms = 8'h00;
      2'h1: step_ms = `STEP_MS_1;
      2'h2: step_ms = `STEP_MS_2;
      2'h3: step_ms = `STEP_MS_3;
    endcase
  endfunction : step_ms

  wire [7:0] start_ms = step_ms(step_sel);
  wire       tick     = (pre_q == PW'(TICK_CYCLES - 1));
  wire       last_ms  = tick && ((ms_q + 8'h01) == target_q);

  // Next state; a start while busy is ignored
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = (start_ms == 8'h00) ? ST_DONE : ST_RUN;
      ST_RUN:  if (last_ms) state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Prescaler from the 1 ms time base, then whole ms
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= ST_IDLE;
      pre_q    <= '0;
      ms_q     <= 8'h00;
      target_q <= 8'h00;
    end
    else if (ce)
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE)
      begin
        pre_q    <= '0;
        ms_q     <= 8'h00;
        target_q <= start_ms; // (R13)
      end
      else if (state_q == ST_RUN)
      begin
        pre_q <= tick ? '0 : pre_q + PW'(1); // (R13)
        ms_q  <= tick ? ms_q + 8'h01 : ms_q; // (R13)
      end
    end
  end

  assign busy = (state_q == ST_RUN);
  assign done = (state_q == ST_DONE);

  // Cycles spent in the run state, seen only by the length check
  logic [31:0] run_cnt_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      run_cnt_q <= 32'h0;
    else if (ce)
      run_cnt_q <= (state_q == ST_RUN) ? run_cnt_q + 32'h1 : 32'h0;
  end

  step_len_a: assert property (@(posedge clock) disable iff (!rst_n) // (R13)
    ($rose(done) && target_q != 8'h00) |->
      (run_cnt_q == 32'(target_q) * 32'(TICK_CYCLES)))
    else $error("routing step length differs from programmed time");

  step_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // (R07)
    (ce && state_q == ST_IDLE && start && start_ms == 8'h00) |=> done)
    else $error("zero length step did not finish at once");

endmodule : step_timer

// ===== sim/host_model.sv
// Host software model: drives the codec control port of the register bank.
// Assumes one clock shared with the bank; tasks are called by the bench.
`timescale 1ns/10ps

module host_model (
  input  wire logic       clock,
  output logic            ce,
  output logic [7:0]      page,
  output logic [7:0]      addr,
  output logic [7:0]      wr_data,
  output logic            wr_en,
  output logic            rd_en
);
  // Quiet bus at time zero so nothing is taken during reset
  initial
  begin
    ce      = 1'b1;
    page    = 8'h01;
    addr    = 8'h00;
    wr_data = 8'h00;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
  end

  // One strobe cycle; released address and data show inverted junk, not stale values, and page returns to 1
  task automatic cycle(input logic [7:0] pg, input logic [7:0] a,
                       input logic [7:0] d, input logic w);
    @(posedge clock);
    page    <= pg;
    addr    <= a;
    wr_data <= d;
    wr_en   <= w;
    rd_en   <= ~w;
    @(posedge clock);
    wr_en   <= 1'b0;
    rd_en   <= 1'b0;
    page    <= 8'h01;
    addr    <= ~a;
    wr_data <= ~d;
  endtask : cycle

  // Clock enable change at an edge
  task automatic set_ce(input logic v);
    @(posedge clock);
    ce <= v;
  endtask : set_ce

  // Line-output write; top bit always written as its default
  task automatic wr_line(input logic [7:0] a, input logic m, input logic [5:0] g);
    cycle(8'h01, a, {1'b0, m, g}, 1'b1);
  endtask : wr_line

  // Headphone startup write, kept clear of forbidden combinations
  task automatic wr_hp(input logic [1:0] s, input logic [3:0] r, input logic [1:0] q);
    logic [1:0] res;
    res = (q == 2'h3) ? 2'h2 : q;
    if (res == 2'h0 && r >= 4'hd)
      res = 2'h1;
    cycle(8'h01, 8'h14, {s, r, res}, 1'b1);
  endtask : wr_hp

  // Random legal gain code: 0..29 dB or -6..-1 dB
  function automatic logic [5:0] rand_gain();
    logic [5:0] g;
    g = 6'($urandom_range(35, 0));
    if (g > 6'd29)
      g = g + 6'h1c;
    return g;
  endfunction : rand_gain
endmodule : host_model

// ===== sim/line_out_gain_hp_startup_regs_bench.sv
// Self-checking bench for the line-output gain and headphone startup bank.
// Assumes the host model beside it and a short time base for step timing.
`timescale 1ns/10ps

module line_out_gain_hp_startup_regs_bench;
  import line_out_pkg::*;
  localparam int unsigned TICK = 10;
  localparam logic [15:0] TC [16] = '{16'd0, 16'd500, 16'd625, 16'd725, 16'd875,
    16'd1000, 16'd2000, 16'd3000, 16'd4000, 16'd5000, 16'd6000, 16'd7000,
    16'd8000, 16'd16000, 16'd32000, 16'd32000};
  localparam int MS [4] = '{0, 50, 100, 200};

  logic        clock = 1'b0;
  logic        rst_n;
  logic        route_step_req;
  logic        ce;
  logic [7:0]  page;
  logic [7:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rd_data;
  logic        lm;
  gain_t       lg;
  logic        rm;
  gain_t       rg;
  step_sel_t   ssel;
  ramp_code_t  rcode;
  res_sel_t    rsel;
  logic        ramp_en;
  logic [15:0] tc;
  logic        busy;
  logic        done;
  logic        fault;
  int          mismatches = 0;
  int          comparisons = 0;
  logic [7:0]  exp_q [$];
  logic        rd_prev = 1'b0;
  logic [6:0]  lv [2];
  int          n;

  // 10 MHz clock
  always #50 clock = ~clock;

  host_model u_host (
    .clock(clock), .ce(ce), .page(page), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en)
  );

  line_out_gain_hp_startup_regs #(.TICK_CYCLES(TICK)) u_dut (
    .clock(clock), .rst_n(rst_n), .ce(ce), .page(page), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .route_step_req(route_step_req), .left_line_output_mute(lm),
    .left_line_output_gain(lg), .right_line_output_mute(rm),
    .right_line_output_gain(rg), .route_step_sel(ssel), .ramp_code(rcode),
    .charge_res_sel(rsel), .ramp_enable(ramp_en), .ramp_tc_milli(tc),
    .route_step_busy(busy), .route_step_done(done), .cfg_fault(fault)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Read: the note goes on the queue, the monitor compares
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.cycle(pg, a, 8'h00, 1'b0);
  endtask : rd

  // Both line-output channels against the expected state
  task automatic check_lines();
    #1;
    check({lm, lg}, lv[0], "left line output");
    check({rm, rg}, lv[1], "right line output");
  endtask : check_lines

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Read data stands only in the cycle after the strobe
  always @(posedge clock)
  begin
    if (rd_prev)
    begin
      if (exp_q.size() == 0)
        check(16'h1, 16'h0, "read without note");
      else
        check(rd_data, exp_q.pop_front(), "read data");
    end
    rd_prev = rd_en && ce && rst_n;
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clock);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    rst_n = 1'b0;
    route_step_req = 1'b0;
    lv = '{7'h40, 7'h40};
    void'($urandom(32'h61332796));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    check_lines();
    check({ssel, rcode, rsel, ramp_en}, 16'h0, "startup reset");
    rd(8'h01, 8'h12, 8'h40);
    rd(8'h01, 8'h13, 8'h40);
    rd(8'h01, 8'h14, 8'h00);
    // Random legal gains and mutes on alternating channels
    for (int i = 0; i < 16; i++)
    begin
      lv[i % 2] = {1'($urandom_range(1, 0)), u_host.rand_gain()};
      u_host.wr_line(8'h12 + 8'(i % 2), lv[i % 2][6], lv[i % 2][5:0]);
      check_lines();
      rd(8'h01, 8'h12 + 8'(i % 2), {1'b0, lv[i % 2]});
    end
    // Top bit set by a careless write is not kept; legal gain, so no fault lingers
    u_host.cycle(8'h01, 8'h13, 8'hfa, 1'b1);
    lv[1] = 7'h7a;
    rd(8'h01, 8'h13, 8'h7a);
    // Wrong page, unmapped place, and a write with the enable low
    u_host.cycle(8'h00, 8'h12, 8'h3a, 1'b1);
    u_host.cycle(8'h01, 8'h15, 8'h3a, 1'b1);
    u_host.set_ce(1'b0);
    u_host.cycle(8'h01, 8'h12, 8'h3a, 1'b1);
    u_host.set_ce(1'b1);
    check_lines();
    rd(8'h00, 8'h12, 8'h00);
    rd(8'h01, 8'h15, 8'h00);
    // Reserved gain code is reported two cycles after the write
    u_host.cycle(8'h01, 8'h12, 8'h20, 1'b1);
    repeat (2) @(posedge clock);
    #1 check(fault, 16'h1, "reserved gain fault");
    rd(8'h01, 8'h7f, 8'h04);
    u_host.wr_line(8'h12, lv[0][6], lv[0][5:0]);
    repeat (2) @(posedge clock);
    #1 check(fault, 16'h0, "fault cleared");
    // Every ramp code once, with step time and resistance cycling alongside
    for (int r = 0; r < 16; r++)
    begin
      n = ((r >= 13) && (r % 3 == 0)) ? 1 : r % 3;
      u_host.wr_hp(2'(r), 4'(r), 2'(n));
      #1 check({ssel, rcode, rsel}, {2'(r), 4'(r), 2'(n)}, "startup fields");
      @(posedge clock);
      #1 check(ramp_en, 16'(r != 0), "ramp enable");
      check(tc, TC[r], "ramp length");
      rd(8'h01, 8'h14, {2'(r), 4'(r), 2'(n)});
    end
    // Step timing for each select, with a request ignored while busy
    for (int s = 0; s < 4; s++)
    begin
      u_host.wr_hp(2'(s), 4'h0, 2'h0);
      @(posedge clock);
      route_step_req <= 1'b1;
      @(posedge clock);
      route_step_req <= 1'b0;
      n = 0;
      #1;
      while (done !== 1'b1 && busy === 1'b1 && n < 3000)
      begin
        @(posedge clock);
        n++;
        route_step_req <= (n == 100);
        #1;
      end
      check(16'(n), 16'(MS[s] * TICK), "step length");
      check({busy, done}, 16'h1, "step end");
      @(posedge clock);
      #1 check(done, 16'h0, "done pulse");
    end
    // Sticky step done shows once in the status word, then clears
    rd(8'h01, 8'h7f, 8'h02);
    rd(8'h01, 8'h7f, 8'h00);
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule : line_out_gain_hp_startup_regs_bench
